//--- pkg/sci_pkg.sv
// Shared constants, types and register map of the command target block.
// Assumes one clock domain and a plain single-cycle register port.
package sci_pkg;

  // ==========================================================================
  // Command bytes and field positions
  localparam logic [7:0] OP_INQUIRY      = 8'h12;
  localparam logic [7:0] OP_COPY_VERIFY  = 8'h3A;
  localparam int         CDB_LEN         = 10;
  localparam int         CDB1_VITAL_PRODUCT_DATA_FLAG_BIT   = 0;
  localparam int         CDB1_PAD_BIT    = 0;
  localparam int         CDB1_BYTE_COMPARE_FLAG_BIT = 1;
  localparam int         CDB1_LUN_MSB    = 7;
  localparam int         CDB1_LUN_LSB    = 5;

  // ==========================================================================
  // Register offsets and bit positions
  localparam logic [7:0] ADDR_CDB_LAST = 8'h09;
  localparam logic [7:0] ADDR_GO       = 8'h10;
  localparam logic [7:0] ADDR_CFG      = 8'h11;
  localparam logic [7:0] ADDR_SEGLEN   = 8'h12;
  localparam logic [7:0] ADDR_SEGCNT   = 8'h13;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_INFO     = 8'h15;
  localparam int         CFG_READY_BIT = 0;
  localparam int         CFG_MEDIA_BIT = 1;
  localparam int         CFG_FW_BIT    = 2;
  localparam int         CFG_UA_BIT    = 3;
  localparam int         SEG_CAT_BIT   = 24;
  localparam int         SEG_LAST_BIT  = 25;

  // ==========================================================================
  // Status, sense keys and additional codes
  localparam logic [7:0] STS_GOOD       = 8'h00;
  localparam logic [7:0] STS_CHECK      = 8'h02;
  localparam logic [3:0] KEY_NONE       = 4'h0;
  localparam logic [3:0] KEY_NOT_READY  = 4'h2;
  localparam logic [3:0] KEY_MEDIUM     = 4'h3;
  localparam logic [3:0] KEY_ILLEGAL    = 4'h5;
  localparam logic [3:0] KEY_UNIT_ATTN  = 4'h6;
  localparam logic [3:0] KEY_MISCOMPARE = 4'hE;
  localparam logic [7:0] ASC_NONE       = 8'h00;
  localparam logic [7:0] ASC_NOT_READY  = 8'h04;
  localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
  localparam logic [7:0] ASC_BAD_CDB    = 8'h24;
  localparam logic [7:0] ASC_BAD_PARAM  = 8'h26;
  localparam logic [7:0] ASC_UNIT_ATTN  = 8'h29;

  // ==========================================================================
  // Inquiry data
  localparam logic [7:0] PAD_BYTE    = 8'h00;
  localparam logic [7:0] SPACE_BYTE  = 8'h20;
  localparam logic [7:0] NO_LUN_BYTE = 8'h7F;
  localparam logic [7:0] INQ_STD_LEN = 8'd36;
  localparam logic [7:0] INQ_ADD_LEN = 8'd31;
  localparam logic [7:0] VPD_LEN     = 8'd5;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_DECODE = 4'b0001, S_LOAD = 4'b0011, S_COPY = 4'b0010,
    S_PAD  = 4'b0110, S_SEGW   = 4'b0111, S_VFY  = 4'b0101, S_DONE = 4'b0100,
    S_INQ  = 4'b1100
  } sci_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sci_byte_s;

  typedef struct packed {
    logic       valid;
    logic       mediumErr;
    logic [7:0] rdData;
    logic [7:0] srcData;
  } sci_vfy_s;

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] key;
    logic [7:0] asc;
  } sci_sense_s;

endpackage

//--- rtl/sci_inq_rom.sv
// Inquiry response image: standard data or the supported-pages list.
// Assumes the caller never indexes past the response length.
module sci_inq_rom
  import sci_pkg::*;
#(
  parameter logic [63:0]  VENDOR_ID  = 64'h5645_4E44_3030_3031, // Arbitrary value
  parameter logic [127:0] PRODUCT_ID = 128'h5052_4F44_3030_3031_2020_2020_2020_2020, // Arbitrary
  parameter logic [31:0]  REVISION   = 32'h3031_3030, // Arbitrary value
  parameter logic [4:0]   DEV_TYPE   = 5'h00,
  parameter logic [7:0]   VERSION    = 8'h02,
  parameter logic [7:0]   RESP_FMT   = 8'h02,
  parameter logic [7:0]   CAPS_MIN   = 8'h00,
  parameter logic [7:0]   CAPS_FULL  = 8'h02
) (
  // Selection
  input  wire logic [7:0] idx,
  input  wire logic       vpd,
  // Live state
  input  wire logic       lunOk,
  input  wire logic       mediaOk,
  input  wire logic       fullFw,
  // Result
  output logic      [7:0] romByte
);

  // ==========================================================================
  // Image assembly
  logic [7:0]   firstByte;
  logic [287:0] stdImg;
  logic [39:0]  vpdImg;
  logic [5:0]   stdRev;
  logic [2:0]   vpdRev;

  // Revision lives on the medium, so spaces stand in until it can be read
  always_comb begin
    firstByte = lunOk ? {3'b000, DEV_TYPE} : NO_LUN_BYTE;
    stdImg    = {firstByte, 8'h00, VERSION, RESP_FMT, INQ_ADD_LEN, 8'h00, 8'h00,
                 fullFw ? CAPS_FULL : CAPS_MIN,
                 VENDOR_ID, PRODUCT_ID,
                 mediaOk ? REVISION : {4{SPACE_BYTE}}};
    vpdImg    = {firstByte, 8'h00, 8'h00, 8'h01, 8'h00};
    stdRev    = 6'(INQ_STD_LEN - 8'd1 - idx);
    vpdRev    = 3'(VPD_LEN - 8'd1 - idx);
    romByte   = vpd ? vpdImg[{vpdRev, 3'b000} +: 8] : stdImg[{stdRev, 3'b000} +: 8];
  end

endmodule

//--- rtl/sci_cmd_target.sv
// Command target for the copy-and-verify and inquiry commands.
// Assumes software loads the command bytes and segments over the register port.
module sci_cmd_target
  import sci_pkg::*;
#(
  parameter logic [2:0] SUPPORTED_LUN = 3'd0,
  parameter logic       VPD_SUPPORTED = 1'b0
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // Source data stream
  input  wire sci_byte_s   srcIn,
  output logic             srcReady,
  // Destination data stream
  output sci_byte_s        dstOut,
  // Verify readback
  input  wire sci_vfy_s    vfyIn,
  output logic             vfyReady,
  // Inquiry data to the initiator and the completion pulse
  output sci_byte_s        inqOut,
  output logic             cmdDone
);

  // ==========================================================================
  // Register state
  logic [7:0]  cdb_r [CDB_LEN];
  logic        cfgReady_r, cfgMedia_r, cfgFw_r, ua_r;
  logic [15:0] segSrcLen_r, segDstLen_r;
  logic [23:0] segBlocks_r;
  logic        segCat_r, segLast_r;
  sci_state_e  state_r, stateNxt;
  sci_sense_s  sense_r, finSense;
  logic [31:0] info_r, finInfo, regRdData_r;
  logic [7:0]  inqIdx_r, sendLimit_r, respLen, romByte;
  logic [15:0] srcInBlk_r, dstInBlk_r;
  logic [23:0] blocksLeft_r;
  logic [31:0] dstTotal_r, vfyCount_r;
  sci_byte_s   inqOut_r, dstOut_r;
  logic        srcReady_r, vfyReady_r, cmdDone_r;
  logic        finish, uaClr, srcTake, srcLast, dstBlkEnd, segEnd, partial;
  logic        vfyTake, emit, goWr, cfgWr, segCntWr;

  // Command fields, shared by both opcodes
  wire logic [7:0] opcode   = cdb_r[0];
  wire logic       vital_product_data_flag     = cdb_r[1][CDB1_VITAL_PRODUCT_DATA_FLAG_BIT];
  wire logic       padFlag  = cdb_r[1][CDB1_PAD_BIT];
  wire logic       byteChk  = cdb_r[1][CDB1_BYTE_COMPARE_FLAG_BIT];
  wire logic       lunOk    = cdb_r[1][CDB1_LUN_MSB:CDB1_LUN_LSB] == SUPPORTED_LUN;
  wire logic [7:0] pageCode = cdb_r[2];
  wire logic [7:0] allocLen = cdb_r[4];
  wire sci_state_e segTail  = segLast_r ? S_VFY : S_SEGW;
  assign goWr     = regWr && regAddr == ADDR_GO;
  assign cfgWr    = regWr && regAddr == ADDR_CFG;
  assign segCntWr = regWr && regAddr == ADDR_SEGCNT;

  // ==========================================================================
  // Software registers
  // Unit attention: a software write in the same cycle beats the hardware clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfgReady_r <= 1'b0;
      cfgMedia_r <= 1'b0;
      cfgFw_r    <= 1'b0;
      ua_r       <= 1'b0;
    end else if (cfgWr) begin
      cfgReady_r <= regWrData[CFG_READY_BIT];
      cfgMedia_r <= regWrData[CFG_MEDIA_BIT];
      cfgFw_r    <= regWrData[CFG_FW_BIT];
      ua_r       <= regWrData[CFG_UA_BIT];
    end else if (uaClr) begin
      ua_r <= 1'b0; // Only a copy reports it; inquiry never clears
    end
  end

  // Command bytes and segment descriptor
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < CDB_LEN; i++) cdb_r[i] <= 8'h00;
      segSrcLen_r <= 16'h0000;
      segDstLen_r <= 16'h0000;
      segBlocks_r <= 24'h000000;
      segCat_r    <= 1'b0;
      segLast_r   <= 1'b0;
    end else if (regWr) begin
      if (regAddr <= ADDR_CDB_LAST) cdb_r[regAddr[3:0]] <= regWrData[7:0];
      if (regAddr == ADDR_SEGLEN) begin
        segSrcLen_r <= regWrData[15:0];
        segDstLen_r <= regWrData[31:16];
      end
      if (segCntWr) begin
        segBlocks_r <= regWrData[23:0];
        segCat_r    <= regWrData[SEG_CAT_BIT];
        segLast_r   <= regWrData[SEG_LAST_BIT];
      end
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (reset || !regRd) begin
      regRdData_r <= 32'h0000_0000;
    end else if (regAddr <= ADDR_CDB_LAST) begin
      regRdData_r <= {24'h000000, cdb_r[regAddr[3:0]]};
    end else begin
      case (regAddr)
        ADDR_CFG:    regRdData_r <= {28'h0000000, ua_r, cfgFw_r, cfgMedia_r, cfgReady_r};
        ADDR_SEGLEN: regRdData_r <= {segDstLen_r, segSrcLen_r};
        ADDR_SEGCNT: regRdData_r <= {6'h00, segLast_r, segCat_r, segBlocks_r};
        ADDR_STATUS: regRdData_r <= {6'h00, state_r == S_SEGW, state_r != S_IDLE,
                                     sense_r.asc, 4'h0, sense_r.key, sense_r.status};
        ADDR_INFO:   regRdData_r <= info_r;
        default:     regRdData_r <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Sequencer
  assign srcTake   = state_r == S_COPY && srcIn.valid && srcReady_r;
  assign srcLast   = srcTake && srcInBlk_r == segSrcLen_r - 16'd1 && blocksLeft_r == 24'd1;
  assign dstBlkEnd = dstInBlk_r == segDstLen_r - 16'd1;
  assign emit      = srcTake || state_r == S_PAD;
  assign vfyTake   = state_r == S_VFY && vfyIn.valid && vfyReady_r && vfyCount_r != dstTotal_r;
  assign partial   = (state_r == S_LOAD) ? dstInBlk_r != 16'd0 : !dstBlkEnd;

  // Next state and final sense; a finish always lands in the done state
  always_comb begin
    stateNxt = state_r;
    finish   = 1'b0;
    uaClr    = 1'b0;
    segEnd   = 1'b0;
    finSense = '{STS_GOOD, KEY_NONE, ASC_NONE};
    finInfo  = 32'h0000_0000;
    case (state_r)
      S_IDLE: if (goWr) stateNxt = S_DECODE;
      S_DECODE: begin
        if (opcode == OP_INQUIRY) begin
          // Readiness and unit attention are ignored here
          if ((vital_product_data_flag && !VPD_SUPPORTED) || pageCode != 8'h00) begin
            finish   = 1'b1;
            finSense = '{STS_CHECK, KEY_ILLEGAL, ASC_BAD_CDB};
          end else if (allocLen == 8'h00) begin
            finish = 1'b1;
          end else begin
            stateNxt = S_INQ;
          end
        end else if (opcode == OP_COPY_VERIFY) begin
          if (ua_r) begin
            finish   = 1'b1;
            uaClr    = 1'b1;
            finSense = '{STS_CHECK, KEY_UNIT_ATTN, ASC_UNIT_ATTN};
          end else if (!cfgReady_r) begin
            finish   = 1'b1;
            finSense = '{STS_CHECK, KEY_NOT_READY, ASC_NOT_READY};
          end else begin
            stateNxt = S_LOAD;
          end
        end else begin
          finish   = 1'b1;
          finSense = '{STS_CHECK, KEY_ILLEGAL, ASC_BAD_OPCODE};
        end
      end
      S_INQ: if (inqIdx_r == sendLimit_r - 8'd1) finish = 1'b1;
      S_LOAD: begin
        // Concatenate on the last segment is refused rather than trusted
        if (segSrcLen_r == 16'd0 || segDstLen_r == 16'd0 || (segCat_r && segLast_r)) begin
          finish   = 1'b1;
          finSense = '{STS_CHECK, KEY_ILLEGAL, ASC_BAD_PARAM};
        end else if (segBlocks_r != 24'd0) begin
          stateNxt = S_COPY;
        end else begin
          segEnd = 1'b1;
        end
      end
      S_COPY: segEnd = srcLast;
      S_PAD:  if (dstBlkEnd) stateNxt = segTail;
      S_SEGW: if (segCntWr) stateNxt = S_LOAD;
      S_VFY: begin
        if (vfyCount_r == dstTotal_r) begin
          finish = 1'b1;
        end else if (vfyTake) begin
          finInfo = dstTotal_r - vfyCount_r; // Residue as for a copy failure
          if (byteChk && vfyIn.rdData != vfyIn.srcData) begin
            finish   = 1'b1;
            finSense = '{STS_CHECK, KEY_MISCOMPARE, ASC_NONE};
          end else if (vfyIn.mediumErr) begin
            finish   = 1'b1;
            finSense = '{STS_CHECK, KEY_MEDIUM, ASC_NONE};
          end else if (vfyCount_r == dstTotal_r - 32'd1) begin
            finish  = 1'b1;
            finInfo = 32'h0000_0000;
          end
        end
      end
      S_DONE:  stateNxt = S_IDLE;
      default: stateNxt = S_IDLE;
    endcase
    // Inexact tail: pad and concatenate flags pick the action
    if (segEnd) begin
      if (!partial || segCat_r) begin
        stateNxt = segTail;
      end else if (padFlag) begin
        stateNxt = S_PAD;
      end else begin
        finish   = 1'b1;
        finSense = '{STS_CHECK, KEY_ILLEGAL, ASC_BAD_PARAM};
        finInfo  = {16'h0000, dstInBlk_r};
      end
    end
    if (finish) stateNxt = S_DONE;
  end

  // State, sense and completion pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r   <= S_IDLE;
      sense_r   <= '{STS_GOOD, KEY_NONE, ASC_NONE};
      info_r    <= 32'h0000_0000;
      cmdDone_r <= 1'b0;
    end else begin
      state_r   <= stateNxt;
      cmdDone_r <= finish;
      if (finish) begin
        sense_r <= finSense;
        info_r  <= finInfo;
      end
    end
  end

  // ==========================================================================
  // Inquiry transfer
  assign respLen = vital_product_data_flag ? VPD_LEN : INQ_STD_LEN;
  always_ff @(posedge mclk) begin
    if (reset) begin
      inqIdx_r    <= 8'h00;
      sendLimit_r <= 8'h00;
    end else if (state_r == S_DECODE) begin
      inqIdx_r    <= 8'h00;
      sendLimit_r <= (allocLen < respLen) ? allocLen : respLen;
    end else if (state_r == S_INQ) begin
      inqIdx_r <= inqIdx_r + 8'd1;
    end
  end

  sci_inq_rom u_rom (
    .idx     (inqIdx_r),
    .vpd     (vital_product_data_flag),
    .lunOk   (lunOk),
    .mediaOk (cfgMedia_r),
    .fullFw  (cfgFw_r),
    .romByte (romByte)
  );

  // ==========================================================================
  // Copy and verify counters
  // Destination block count spans segments so a concatenated one fills the open block
  always_ff @(posedge mclk) begin
    if (reset || state_r == S_DECODE) begin
      srcInBlk_r   <= 16'd0;
      blocksLeft_r <= 24'd0;
      dstInBlk_r   <= 16'd0;
      dstTotal_r   <= 32'd0;
      vfyCount_r   <= 32'd0;
    end else begin
      if (state_r == S_LOAD) begin
        srcInBlk_r   <= 16'd0;
        blocksLeft_r <= segBlocks_r;
      end else if (srcTake) begin
        srcInBlk_r <= (srcInBlk_r == segSrcLen_r - 16'd1) ? 16'd0 : srcInBlk_r + 16'd1;
        if (srcInBlk_r == segSrcLen_r - 16'd1) blocksLeft_r <= blocksLeft_r - 24'd1;
      end
      if (emit) begin
        dstInBlk_r <= dstBlkEnd ? 16'd0 : dstInBlk_r + 16'd1;
        dstTotal_r <= dstTotal_r + 32'd1;
      end
      if (vfyTake) vfyCount_r <= vfyCount_r + 32'd1;
    end
  end
  // Streams out; ready is registered so it looks at the next state
  always_ff @(posedge mclk) begin
    if (reset) begin
      inqOut_r   <= '{1'b0, 8'h00};
      dstOut_r   <= '{1'b0, 8'h00};
      srcReady_r <= 1'b0;
      vfyReady_r <= 1'b0;
    end else begin
      inqOut_r   <= '{state_r == S_INQ, romByte};
      dstOut_r   <= '{emit, (state_r == S_PAD) ? PAD_BYTE : srcIn.data};
      srcReady_r <= stateNxt == S_COPY;
      vfyReady_r <= stateNxt == S_VFY;
    end
  end
  assign regRdData = regRdData_r;
  assign srcReady  = srcReady_r;
  assign vfyReady  = vfyReady_r;
  assign dstOut    = dstOut_r;
  assign inqOut    = inqOut_r;
  assign cmdDone   = cmdDone_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_PAD_ZERO: assert property (state_r == S_PAD |=> dstOut_r.valid && dstOut_r.data == 8'h00)
    else $error("pad byte not zero");
  AST_PAD_BOUNDARY: assert property (state_r == S_PAD && dstBlkEnd |=> dstInBlk_r == 16'd0)
    else $error("pad stopped off a block boundary");
  AST_CAT_NO_PAD: assert property (srcLast && segCat_r |=> state_r != S_PAD)
    else $error("concatenated segment was padded");
  AST_RAW_INEXACT: assert property (srcLast && !segCat_r && !padFlag && !dstBlkEnd
    |=> state_r == S_DONE && sense_r.key == KEY_ILLEGAL)
    else $error("inexact segment not rejected");
  AST_MISCOMPARE: assert property (vfyTake && byteChk && vfyIn.rdData != vfyIn.srcData
    |=> sense_r.status == STS_CHECK && sense_r.key == KEY_MISCOMPARE ##1 state_r == S_IDLE)
    else $error("miscompare not reported");
  AST_NO_COMPARE: assert property (vfyTake && !byteChk && !vfyIn.mediumErr &&
    vfyCount_r != dstTotal_r - 32'd1 |=> state_r == S_VFY)
    else $error("verify compared data without byte check");
  AST_VPD_REJECT: assert property (state_r == S_DECODE && opcode == OP_INQUIRY &&
    vital_product_data_flag && !VPD_SUPPORTED |=> sense_r.key == KEY_ILLEGAL && sense_r.asc == ASC_BAD_CDB)
    else $error("unsupported page request accepted");
  AST_PAGE_REJECT: assert property (state_r == S_DECODE && opcode == OP_INQUIRY &&
    !vital_product_data_flag && pageCode != 8'h00 |=> state_r == S_DONE && sense_r.status == STS_CHECK)
    else $error("nonzero page code accepted");
  AST_UA_KEPT: assert property (state_r == S_INQ && ua_r && !cfgWr |=> ua_r)
    else $error("inquiry cleared unit attention");
  AST_TRUNCATE: assert property (inqOut_r.valid && !$past(inqOut_r.valid)
    |-> sendLimit_r <= allocLen && sendLimit_r <= INQ_STD_LEN)
    else $error("inquiry exceeds allocation");
  AST_NO_LUN: assert property (state_r == S_INQ && inqIdx_r == 8'h00 && !lunOk
    |=> inqOut_r.data == NO_LUN_BYTE)
    else $error("bad first byte for missing unit");
  COV_INQ_FULL: cover property (state_r == S_INQ && inqIdx_r == INQ_STD_LEN - 8'd1);
  COV_PAD:      cover property (state_r == S_PAD ##1 state_r == S_VFY);
  COV_CAT:      cover property (srcLast && segCat_r && !dstBlkEnd);
  COV_MISCMP:   cover property (sense_r.key == KEY_MISCOMPARE && cmdDone_r);
endmodule

//--- dv/sci_far_model.sv
// Far-side model: source byte stream and destination readback store.
// Assumes the bench raises restart before each copy command starts.
module sci_far_model
  import sci_pkg::*;
(
  // Clock and control
  input  wire logic       mclk,
  input  wire logic       restart,
  input  wire logic [7:0] badIdx,
  input  wire logic       medFault,
  // Copy engine side
  input  wire logic       srcReady,
  input  wire sci_byte_s  dstOut,
  input  wire logic       vfyReady,
  output sci_byte_s       srcIn,
  output sci_vfy_s        vfyIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] store [0:255];
  logic [7:0] srcCnt;
  logic [7:0] wrIdx;
  logic [7:0] vIdx;
  // ==========================================================================
  // Stream state; the source never stalls, so acceptance must be exact
  always_ff @(posedge mclk) begin
    if (restart) begin
      srcCnt <= 8'hA0;
      wrIdx <= 8'h00;
      vIdx <= 8'h00;
    end else begin
      if (srcReady) srcCnt <= srcCnt + 8'h01;
      if (dstOut.valid) store[wrIdx] <= dstOut.data;
      if (dstOut.valid) wrIdx <= wrIdx + 8'h01;
      if (vfyReady) vIdx <= vIdx + 8'h01;
    end
  end
  // Readback flips one chosen byte, and may flag a medium fault on it
  assign srcIn = '{valid: 1'b1, data: srcCnt};
  assign vfyIn = '{valid: 1'b1, mediumErr: medFault && vIdx == badIdx, srcData: store[vIdx],
                   rdData: store[vIdx] ^ ((vIdx == badIdx) ? 8'h01 : 8'h00)};
endmodule

//--- dv/sci_cmd_target_test.sv
// Bench for the command target: inquiry and copy-and-verify paths.
// Assumes the far-side model feeds source bytes and readback.
module sci_cmd_target_test
  import sci_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        restart = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  badIdx = 8'hFF;
  logic        medFault = 1'b0;
  logic [31:0] regWrData = 32'h0;
  logic [31:0] regRdData;
  logic [31:0] rdVal;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        srcReady, vfyReady, cmdDone;
  sci_byte_s   srcIn, dstOut, inqOut;
  sci_vfy_s    vfyIn;
  logic [7:0]  inqBuf [0:63];
  logic [7:0]  dstBuf [0:63];
  int          nInq, nDst;
  int          err_count = 0;
  int          samples_checked = 0;
  always #12.5 mclk = ~mclk;
  sci_cmd_target dut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcIn(srcIn), .srcReady(srcReady),
    .dstOut(dstOut), .vfyIn(vfyIn), .vfyReady(vfyReady), .inqOut(inqOut), .cmdDone(cmdDone));
  sci_far_model far (.mclk(mclk), .restart(restart), .badIdx(badIdx), .medFault(medFault),
    .srcReady(srcReady), .dstOut(dstOut), .vfyReady(vfyReady), .srcIn(srcIn), .vfyIn(vfyIn));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  task automatic cdb(input logic [7:0] b0, b1, b2, b4);
    wr(8'h00, {24'h0, b0});
    wr(8'h01, {24'h0, b1});
    wr(8'h02, {24'h0, b2});
    wr(8'h04, {24'h0, b4});
  endtask
  // Start the loaded command and gather both output streams until done
  task automatic run();
    restart <= 1'b1;
    wr(ADDR_GO, 32'h0);
    restart <= 1'b0;
    nInq = 0;
    nDst = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      #1;
      if (inqOut.valid === 1'b1) inqBuf[nInq[5:0]] = inqOut.data;
      if (inqOut.valid === 1'b1) nInq++;
      if (dstOut.valid === 1'b1) dstBuf[nDst[5:0]] = dstOut.data;
      if (dstOut.valid === 1'b1) nDst++;
      if (cmdDone === 1'b1) break;
    end
    chk({31'h0, cmdDone}, 32'h1);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic inq(input logic [7:0] b1, pg, alloc, input int n,
                     input logic [7:0] st, input logic [3:0] key, input logic [7:0] asc, b0);
    cdb(OP_INQUIRY, b1, pg, alloc);
    run();
    chk(nInq, n);
    rd(ADDR_STATUS);
    chk(rdVal, {8'h00, asc, 4'h0, key, st});
    if (n > 0) chk(inqBuf[0], b0);
    $display("test inquiry done");
  endtask
  // One segment, one 2-byte source block into one 4-byte destination block
  task automatic copy(input logic [7:0] b1, input logic [3:0] key, input logic [7:0] asc,
                      input int n, input int info);
    cdb(OP_COPY_VERIFY, b1, 8'h00, 8'h0C);
    wr(ADDR_SEGLEN, {16'd4, 16'd2});
    wr(ADDR_SEGCNT, 32'h0200_0001);
    run();
    chk(nDst, n);
    rd(ADDR_STATUS);
    chk(rdVal, {8'h00, asc, 4'h0, key, (key == KEY_NONE) ? STS_GOOD : STS_CHECK});
    if (info >= 0) rd(ADDR_INFO);
    if (info >= 0) chk(rdVal, info);
    $display("test copy done");
  endtask
  // Two segments; the open block of the first is filled from the second
  task automatic concat();
    cdb(OP_COPY_VERIFY, 8'h00, 8'h00, 8'h18);
    wr(ADDR_SEGLEN, {16'd4, 16'd2});
    wr(ADDR_SEGCNT, 32'h0100_0001);
    fork
      run();
      begin
        repeat (12) @(posedge mclk);
        wr(ADDR_SEGCNT, 32'h0200_0001);
      end
    join
    chk(nDst, 4);
    chk({dstBuf[0], dstBuf[1], dstBuf[2], dstBuf[3]}, {8'hA0, 8'hA1, 8'hA2, 8'hA3});
    rd(ADDR_STATUS);
    chk(rdVal, 32'h0);
    $display("test concatenate done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    badIdx <= 8'h01;
    wr(ADDR_CFG, 32'h8);
    inq(8'h00, 8'h00, 8'd36, 36, STS_GOOD, KEY_NONE, ASC_NONE, 8'h00);
    chk({inqBuf[32], inqBuf[7]}, {SPACE_BYTE, 8'h00});
    inq(8'h00, 8'h00, 8'd4, 4, STS_GOOD, KEY_NONE, ASC_NONE, 8'h00);
    inq(8'h20, 8'h00, 8'd36, 36, STS_GOOD, KEY_NONE, ASC_NONE, NO_LUN_BYTE);
    inq(8'h01, 8'h00, 8'd36, 0, STS_CHECK, KEY_ILLEGAL, ASC_BAD_CDB, 8'h00);
    inq(8'h00, 8'h01, 8'd36, 0, STS_CHECK, KEY_ILLEGAL, ASC_BAD_CDB, 8'h00);
    rd(ADDR_CFG);
    chk(rdVal, 32'h8);
    wr(ADDR_CFG, 32'h6);
    inq(8'h00, 8'h00, 8'd36, 36, STS_GOOD, KEY_NONE, ASC_NONE, 8'h00);
    chk(inqBuf[7], 8'h02);
    wr(ADDR_CFG, 32'h9);
    copy(8'h01, KEY_UNIT_ATTN, ASC_UNIT_ATTN, 0, -1);
    copy(8'h01, KEY_NONE, ASC_NONE, 4, -1);
    chk({dstBuf[0], dstBuf[1], dstBuf[2], dstBuf[3]}, {8'hA0, 8'hA1, PAD_BYTE, PAD_BYTE});
    copy(8'h03, KEY_MISCOMPARE, ASC_NONE, 4, 3);
    medFault <= 1'b1;
    copy(8'h01, KEY_MEDIUM, ASC_NONE, 4, 3);
    medFault <= 1'b0;
    copy(8'h00, KEY_ILLEGAL, ASC_BAD_PARAM, 2, 1);
    concat();
    wr(ADDR_CFG, 32'h0);
    copy(8'h01, KEY_NOT_READY, ASC_NOT_READY, 0, -1);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    final_report();
  end
endmodule
